// ===== design/bram_bridge_pkg.sv
// Package with types, modes and constants of the AXI4 block RAM bridge.
package bram_bridge_pkg;

	// Burst type encodings on the address channels.
	localparam logic [1:0] BURST_FIXED = 2'h0;
	localparam logic [1:0] BURST_INCR = 2'h1;
	localparam logic [1:0] BURST_WRAP = 2'h2;

	// Response encodings.
	localparam logic [1:0] RESP_OKAY = 2'h0;

	// Slave operating modes.
	localparam logic [1:0] MODE_MEM_FULL = 2'h0;
	localparam logic [1:0] MODE_MEM_LITE = 2'h1;
	localparam logic [1:0] MODE_PER_FULL = 2'h2;
	localparam logic [1:0] MODE_PER_LITE = 2'h3;

	// Address range that memory modes must decode at least, in bytes.
	localparam int MEM_MIN_BYTES = 4096;
	// Least depth of a peripheral mode memory.
	localparam int PER_MIN_DEPTH = 2;
	// Largest incrementing burst length field value.
	localparam logic [7:0] INCR_LEN_MAX = 8'hFF;

	// Legal wrap burst length field values (2, 4, 8, 16 transfers).
	localparam logic [7:0] WRAP_LEN_2 = 8'h01;
	localparam logic [7:0] WRAP_LEN_4 = 8'h03;
	localparam logic [7:0] WRAP_LEN_8 = 8'h07;
	localparam logic [7:0] WRAP_LEN_16 = 8'h0F;

	// Address tracking for one burst in flight.
	typedef struct packed {
		logic [31:0] addr;
		logic [7:0] len;
		logic [2:0] size;
		logic [1:0] burst;
		logic [7:0] count;
		logic first;
	} burst_t;

	// Write side channel states.
	typedef enum logic [1:0] {W_IDLE, W_DATA, W_RESP} wstate_t;
	// Read side channel states.
	typedef enum logic [1:0] {R_IDLE, R_READ, R_WAIT} rstate_t;

	// Next beat address: hold, increment or wrap within a (len+1) << size byte window.
	function automatic logic [31:0] next_addr(input burst_t b);
		logic [31:0] step;
		logic [31:0] win;
		logic [31:0] inc;
		step = 32'h1 << b.size;
		win = ({24'h0, b.len} + 32'h1) << b.size;
		inc = b.addr + step;
		if (b.burst == BURST_FIXED)
			next_addr = b.addr;
		else if (b.burst == BURST_WRAP)
			next_addr = (b.addr & ~(win - 32'h1)) | (inc & (win - 32'h1));
		else
			next_addr = (b.addr & ~(step - 32'h1)) + step;
	endfunction : next_addr

endpackage : bram_bridge_pkg

// ===== design/bram_store.sv
// Simple dual-port RAM with byte write enables and a registered read port.
`timescale 1ns/1ps
module bram_store #(
	parameter int DW = 32,
	parameter int AW = 10
) (
	// Clock.
	input wire logic clk,
	// Write port.
	input wire logic [DW/8-1:0] we,
	input wire logic [AW-1:0] waddr,
	input wire logic [DW-1:0] wdata,
	// Read port.
	input wire logic re,
	input wire logic [AW-1:0] raddr,
	output logic [DW-1:0] rdata
);

	logic [DW-1:0] mem [2**AW];

	// Each byte lane is written only when its enable is set.
	always_ff @(posedge clk)
	begin
		for (int i = 0; i < DW / 8; i++)
		begin
			if (we[i])
				mem[waddr][i*8 +: 8] <= wdata[i*8 +: 8];
		end
		if (re)
			rdata <= mem[raddr];
	end

endmodule : bram_store

// ===== design/axi_bram_bridge.sv
// AXI4 slave that generates block RAM addresses and byte enables for bursts.
// Behaviour
// - Wrap bursts are only 2, 4, 8 or 16 transfers long; the bridge takes other wrap lengths unchecked.
// - Burst type binary 10 requests and is decoded as wrap.
// - Wrap addresses climb from the target word to the boundary, then restart.
// - Narrow wrap beats step by the transfer size inside length times size.
// - Valid byte lanes of narrow bursts rotate with the current byte address.
// - Each bus data beat gives exactly one memory access.
// - Write strobes, masked to the lanes the current address owns, drive the memory byte write enables.
// - Narrow writes reuse the word address until a word boundary is crossed.
// - Unaligned word bursts are carried out, never rejected.
// - Data width is 32 to 256 for memory modes, down to 8 for peripheral.
// - Memory modes decode at least a 4 kB address range.
// - Peripheral modes need no least address width; depth may be two.
// - Peripheral and lite memory modes treat byte offset bits as zero.
// - Full memory mode decodes low byte address bits for narrow transfers.
// - Write response valid once per burst, after the last data beat.
// - Write data ready stays low until a write address is registered.
// - Incrementing bursts run 1 to 256 transfers; length field is count minus one.
// - Read pipeline holds while the master keeps read data ready low.
`timescale 1ns/1ps
module axi_bram_bridge #(
	parameter int DATA_WIDTH = 32,
	parameter int MEM_DEPTH = 1024,
	parameter logic [1:0] MODE = bram_bridge_pkg::MODE_MEM_FULL
) (
	// Clock and reset.
	input wire logic CLK,
	input wire logic RST,
	// Write address channel.
	input wire logic AWVALID,
	output logic AWREADY,
	input wire logic [31:0] AWADDR,
	input wire logic [7:0] AWLEN,
	input wire logic [2:0] AWSIZE,
	input wire logic [1:0] AWBURST,
	// Write data channel.
	input wire logic WVALID,
	output logic WREADY,
	input wire logic [DATA_WIDTH-1:0] WDATA,
	input wire logic [DATA_WIDTH/8-1:0] WSTRB,
	input wire logic WLAST,
	// Write response channel.
	output logic BVALID,
	input wire logic BREADY,
	output logic [1:0] BRESP,
	// Read address channel.
	input wire logic ARVALID,
	output logic ARREADY,
	input wire logic [31:0] ARADDR,
	input wire logic [7:0] ARLEN,
	input wire logic [2:0] ARSIZE,
	input wire logic [1:0] ARBURST,
	// Read data channel.
	output logic RVALID,
	input wire logic RREADY,
	output logic [DATA_WIDTH-1:0] RDATA,
	output logic [1:0] RRESP,
	output logic RLAST
);

	localparam int NB = DATA_WIDTH / 8;
	localparam int OFS = $clog2(NB);
	localparam int AW = $clog2(MEM_DEPTH);
	localparam bit IS_MEM = (MODE == bram_bridge_pkg::MODE_MEM_FULL) || (MODE == bram_bridge_pkg::MODE_MEM_LITE);
	localparam bit FULL_DEC = (MODE == bram_bridge_pkg::MODE_MEM_FULL);

	// peripheral depth
	// Bad configurations fail elaboration rather than misbehave quietly.
	generate
		if (DATA_WIDTH < 8 || DATA_WIDTH > 256)
		begin : g_bad_any_width
			$error("Data width must lie between 8 and 256 bits.");
		end
		if (IS_MEM && (DATA_WIDTH < 32 || DATA_WIDTH > 256))
		begin : g_bad_mem_width
			$error("Memory modes take data widths of 32 to 256 bits only.");
		end
		if (MODE[0] && DATA_WIDTH > 64)
		begin : g_bad_lite_width
			$error("Lite modes take data widths of 64 bits at most.");
		end
		if (IS_MEM && MEM_DEPTH * NB < bram_bridge_pkg::MEM_MIN_BYTES)
		begin : g_bad_mem_depth
			$error("Memory modes must decode at least a 4 kB range.");
		end
		if (MEM_DEPTH < bram_bridge_pkg::PER_MIN_DEPTH)
		begin : g_bad_depth
			$error("Memory depth must be at least two words.");
		end
	endgenerate

	// State of both channel machines, one register; memory and its read register sit in u_store.
	typedef struct packed {
		bram_bridge_pkg::wstate_t ws;
		bram_bridge_pkg::burst_t wb;
		logic bvalid;
		bram_bridge_pkg::rstate_t rs;
		bram_bridge_pkg::burst_t rb;
		logic rvalid;
		logic rlast;
		logic [DATA_WIDTH-1:0] rhold;
		logic rheld;
	} state_t;

	state_t s_q;
	state_t s_d;

	// Memory port signals.
	logic [NB-1:0] mem_we;
	logic [AW-1:0] mem_waddr;
	logic mem_re;
	logic [AW-1:0] mem_raddr;
	logic [DATA_WIDTH-1:0] mem_rdata;
	logic [NB-1:0] lane_mask;
	logic w_beat;
	logic r_beat;

	// Clears byte offset bits where the mode does not decode them.
	function automatic logic [31:0] mode_addr(input logic [31:0] a);
		if (FULL_DEC)
			mode_addr = a;
		else
			mode_addr = a & ~((32'h1 << OFS) - 32'h1);
	endfunction : mode_addr

	// Lanes at and above the byte address, up to the end of the transfer size.
	function automatic logic [NB-1:0] lanes(input logic [31:0] a, input logic [2:0] sz);
		logic [31:0] lo;
		logic [31:0] hi;
		logic [31:0] msk;
		msk = (32'h1 << OFS) - 32'h1;
		lo = a & msk;
		// An end offset of zero means the transfer runs to the top lane of the word.
		hi = (((a >> sz) << sz) + (32'h1 << sz)) & msk;
		for (int i = 0; i < NB; i++)
			lanes[i] = (32'(i) >= lo) && ((32'(i) < hi) || (hi == 32'h0));
	endfunction : lanes

	// unaligned first beat
	// Strobes pass straight through, cut to the lanes the current address owns.
	assign w_beat = (s_q.ws == bram_bridge_pkg::W_DATA) && WVALID;
	assign lane_mask = lanes(s_q.wb.addr, s_q.wb.size);
	assign mem_we = w_beat ? (WSTRB & lane_mask) : '0;
	assign mem_waddr = AW'(s_q.wb.addr >> OFS);

	// pipeline stall
	// A read is issued only while no unaccepted data sits on the bus.
	assign r_beat = (s_q.rs == bram_bridge_pkg::R_READ) && (!s_q.rvalid || RREADY);
	assign mem_re = r_beat;
	assign mem_raddr = AW'(s_q.rb.addr >> OFS);

	bram_store #(
		.DW(DATA_WIDTH),
		.AW(AW)
	) u_store (
		.clk(CLK),
		.we(mem_we),
		.waddr(mem_waddr),
		.wdata(WDATA),
		.re(mem_re),
		.raddr(mem_raddr),
		.rdata(mem_rdata)
	);

	// Handshake outputs.
	assign AWREADY = (s_q.ws == bram_bridge_pkg::W_IDLE);
	assign WREADY = (s_q.ws == bram_bridge_pkg::W_DATA);
	assign ARREADY = (s_q.rs == bram_bridge_pkg::R_IDLE);

	// Registered answer outputs.
	assign BVALID = s_q.bvalid;
	assign BRESP = bram_bridge_pkg::RESP_OKAY;
	assign RVALID = s_q.rvalid;
	assign RLAST = s_q.rlast;
	assign RRESP = bram_bridge_pkg::RESP_OKAY;
	assign RDATA = s_q.rheld ? s_q.rhold : mem_rdata;

	// Next state of both channel machines.
	always_comb
	begin
		s_d = s_q;
		case (s_q.ws)
			bram_bridge_pkg::W_IDLE:
			begin
				if (AWVALID)
				begin
					// length field
					// Other wrap lengths and all bursts are taken; lite modes force single beats.
					s_d.wb.addr = mode_addr(AWADDR);
					s_d.wb.len = (MODE[0]) ? 8'h00 : AWLEN;
					s_d.wb.size = (FULL_DEC) ? AWSIZE : 3'(OFS);
					s_d.wb.burst = AWBURST;
					s_d.wb.count = 8'h00;
					s_d.wb.first = 1'b1;
					s_d.ws = bram_bridge_pkg::W_DATA;
				end
			end
			bram_bridge_pkg::W_DATA:
			begin
				if (WVALID)
				begin
					s_d.wb.addr = bram_bridge_pkg::next_addr(s_q.wb);
					s_d.wb.count = s_q.wb.count + 8'h01;
					s_d.wb.first = 1'b0;
					if (s_q.wb.count == s_q.wb.len)
					begin
						s_d.bvalid = 1'b1;
						s_d.ws = bram_bridge_pkg::W_RESP;
					end
				end
			end
			bram_bridge_pkg::W_RESP:
			begin
				if (BREADY)
				begin
					s_d.bvalid = 1'b0;
					s_d.ws = bram_bridge_pkg::W_IDLE;
				end
			end
			default:
				s_d.ws = bram_bridge_pkg::W_IDLE;
		endcase

		// Data accepted this cycle leaves the bus; held copy is kept while stalled.
		if (s_q.rvalid && RREADY)
		begin
			s_d.rvalid = 1'b0;
			s_d.rlast = 1'b0;
			s_d.rheld = 1'b0;
		end
		else if (s_q.rvalid && !s_q.rheld)
		begin
			s_d.rhold = mem_rdata;
			s_d.rheld = 1'b1;
		end
		case (s_q.rs)
			bram_bridge_pkg::R_IDLE:
			begin
				if (ARVALID)
				begin
					s_d.rb.addr = mode_addr(ARADDR);
					s_d.rb.len = (MODE[0]) ? 8'h00 : ARLEN;
					s_d.rb.size = (FULL_DEC) ? ARSIZE : 3'(OFS);
					s_d.rb.burst = ARBURST;
					s_d.rb.count = 8'h00;
					s_d.rb.first = 1'b1;
					s_d.rs = bram_bridge_pkg::R_READ;
				end
			end
			bram_bridge_pkg::R_READ:
			begin
				if (r_beat)
				begin
					s_d.rb.addr = bram_bridge_pkg::next_addr(s_q.rb);
					s_d.rb.count = s_q.rb.count + 8'h01;
					s_d.rb.first = 1'b0;
					s_d.rvalid = 1'b1;
					s_d.rheld = 1'b0;
					s_d.rlast = (s_q.rb.count == s_q.rb.len);
					if (s_q.rb.count == s_q.rb.len)
						s_d.rs = bram_bridge_pkg::R_WAIT;
				end
			end
			bram_bridge_pkg::R_WAIT:
			begin
				if (!s_d.rvalid)
					s_d.rs = bram_bridge_pkg::R_IDLE;
			end
			default:
				s_d.rs = bram_bridge_pkg::R_IDLE;
		endcase
	end

	// State register.
	always_ff @(posedge CLK or posedge RST)
	begin
		if (RST)
		begin
			s_q <= '0;
			s_q.ws <= bram_bridge_pkg::W_IDLE;
			s_q.rs <= bram_bridge_pkg::R_IDLE;
		end
		else
			s_q <= s_d;
	end

endmodule : axi_bram_bridge

// ===== tb/bridge_props.sv
// Protocol checker for the AXI block RAM bridge ports.
`timescale 1ns/1ps
module bridge_props #(
	parameter int DATA_WIDTH = 32
) (
	// Clock and reset.
	input wire logic CLK,
	input wire logic RST,
	// Write channels.
	input wire logic AWVALID,
	input wire logic AWREADY,
	input wire logic [7:0] AWLEN,
	input wire logic WVALID,
	input wire logic WREADY,
	input wire logic BVALID,
	input wire logic BREADY,
	input wire logic [1:0] BRESP,
	// Read channels.
	input wire logic ARVALID,
	input wire logic ARREADY,
	input wire logic [7:0] ARLEN,
	input wire logic RVALID,
	input wire logic RREADY,
	input wire logic [DATA_WIDTH-1:0] RDATA,
	input wire logic [1:0] RRESP,
	input wire logic RLAST
);
	default clocking cb @(posedge CLK); endclocking
	default disable iff (RST);
	logic [8:0] wleft_q;
	logic [7:0] rleft_q;
	// Write beats still owed, and read beats owed after the current one, so length errors show up at the ports.
	always_ff @(posedge CLK or posedge RST)
		if (RST)
		begin
			wleft_q <= '0;
			rleft_q <= '0;
		end
		else
		begin
			if (AWVALID && AWREADY)
				wleft_q <= {1'h0, AWLEN} + 9'h1;
			else if (WVALID && WREADY)
				wleft_q <= wleft_q - 9'h1;
			if (ARVALID && ARREADY)
				rleft_q <= ARLEN;
			else if (RVALID && RREADY)
				rleft_q <= rleft_q - 8'h1;
		end
	sequence s_aw;
		AWVALID && AWREADY;
	endsequence
	sequence s_ar_gap;
		ARVALID && ARREADY ##1 !RVALID;
	endsequence
	AST_W_AFTER_AW: assert property (s_aw |=> !AWREADY && WREADY)
		else $error("write data not opened after address");
	AST_W_NEEDS_AW: assert property (AWREADY |-> !WREADY)
		else $error("write data ready without address");
	AST_W_BEAT_OWED: assert property (WVALID && WREADY |-> wleft_q != 9'h0)
		else $error("write beat beyond burst length");
	AST_B_AFTER_LAST: assert property ($rose(BVALID) |-> wleft_q == 9'h0)
		else $error("write response before last beat");
	AST_B_HOLD: assert property (BVALID && !BREADY |=> BVALID)
		else $error("write response dropped early");
	AST_B_OKAY: assert property (BVALID |-> BRESP == bram_bridge_pkg::RESP_OKAY)
		else $error("write response not okay");
	AST_R_FIRST: assert property (s_ar_gap |=> RVALID && RRESP == bram_bridge_pkg::RESP_OKAY)
		else $error("first read beat late");
	AST_R_LAST: assert property (RVALID |-> RLAST == (rleft_q == 8'h0))
		else $error("read last flag misplaced");
	AST_R_HOLD: assert property (RVALID && !RREADY |=> RVALID && $stable(RDATA) && $stable(RLAST))
		else $error("read data moved while stalled");
endmodule : bridge_props

bind axi_bram_bridge bridge_props #(.DATA_WIDTH(DATA_WIDTH)) props (.*);

// ===== tb/axi_master_model.sv
// Behavioural AXI master that issues bursts to the bridge.
`timescale 1ns/1ps
module axi_master_model (
	// Clock.
	input wire logic CLK,
	// Write channels.
	output logic AWVALID, output logic [31:0] AWADDR, output logic [7:0] AWLEN,
	output logic [2:0] AWSIZE, output logic [1:0] AWBURST, input wire logic AWREADY,
	output logic WVALID, output logic [31:0] WDATA, output logic [3:0] WSTRB, output logic WLAST,
	input wire logic WREADY, input wire logic BVALID, output logic BREADY, input wire logic [1:0] BRESP,
	// Read channels.
	output logic ARVALID, output logic [31:0] ARADDR, output logic [7:0] ARLEN,
	output logic [2:0] ARSIZE, output logic [1:0] ARBURST, input wire logic ARREADY,
	input wire logic RVALID, output logic RREADY, input wire logic [31:0] RDATA,
	input wire logic [1:0] RRESP, input wire logic RLAST
);
	initial {AWVALID, WVALID, WLAST, BREADY, ARVALID, RREADY} = '0;
	initial {AWADDR, AWLEN, AWSIZE, AWBURST, WDATA, WSTRB, ARADDR, ARLEN, ARSIZE, ARBURST} = '0;
	// lengths legal by caller; W is offered early to test the wait.
	task automatic wr(input logic [31:0] a, input logic [7:0] l, input logic [2:0] s, input logic [1:0] b,
		input logic [31:0] d [$], input logic [3:0] st [$], output logic [1:0] rsp);
		{AWVALID, AWADDR, AWLEN, AWSIZE, AWBURST} <= {1'h1, a, l, s, b};
		{WVALID, WDATA, WSTRB, WLAST} <= {1'h1, d[0], st[0], l == 8'h0};
		do @(posedge CLK); while (AWREADY !== 1'h1);
		{AWVALID, AWADDR} <= {1'h0, ~a};
		for (int i = 0; i <= l; i++)
		begin
			if (i > 0)
				{WVALID, WDATA, WSTRB, WLAST} <= {1'h1, d[i], st[i], i == l};
			do @(posedge CLK); while (WREADY !== 1'h1);
		end
		// Released data lines show a changed value, never the last one.
		{WVALID, WDATA, WLAST} <= {1'h0, ~WDATA, 1'h0};
		do @(posedge CLK); while (BVALID !== 1'h1);
		BREADY <= 1'h1;
		@(posedge CLK);
		rsp = BRESP;
		BREADY <= 1'h0;
	endtask : wr
	task automatic rd(input logic [31:0] a, input logic [7:0] l, input logic [2:0] s, input logic [1:0] b,
		input int stall, output logic [31:0] q [$], output logic lst);
		{ARVALID, ARADDR, ARLEN, ARSIZE, ARBURST} <= {1'h1, a, l, s, b};
		do @(posedge CLK); while (ARREADY !== 1'h1);
		{ARVALID, ARADDR, RREADY} <= {1'h0, ~a, 1'h1};
		q = {};
		for (int i = 0; i <= l; i++)
		begin
			do @(posedge CLK); while (RVALID !== 1'h1);
			q.push_back(RDATA);
			lst = RLAST;
			if (i == stall)
			begin
				RREADY <= 1'h0;
				repeat (3) @(posedge CLK);
				RREADY <= 1'h1;
			end
		end
		RREADY <= 1'h0;
	endtask : rd
endmodule : axi_master_model

// ===== tb/testbench.sv
// Self-checking bench for the AXI block RAM bridge.
`timescale 1ns/1ps
module testbench;
	logic CLK = 1'h0;
	logic RST = 1'h1;
	int err_total = 0;
	int compares = 0;
	int cycles = 0;
	logic AWVALID, AWREADY, WVALID, WREADY, WLAST, BVALID, BREADY, ARVALID, ARREADY, RVALID, RREADY, RLAST;
	logic [31:0] AWADDR, ARADDR, WDATA, RDATA;
	logic [7:0] AWLEN, ARLEN;
	logic [2:0] AWSIZE, ARSIZE;
	logic [1:0] AWBURST, ARBURST, BRESP, RRESP;
	logic [3:0] WSTRB;
	axi_bram_bridge #(.DATA_WIDTH(32), .MEM_DEPTH(1024), .MODE(bram_bridge_pkg::MODE_MEM_FULL)) dut (.*);
	axi_master_model m (.*);
	always #12.5 CLK = ~CLK;
	// A hang is cut short well beyond the ninety or so cycles the run needs.
	always @(posedge CLK)
	begin
		cycles <= cycles + 1;
		if (cycles == 20000)
		begin
			err_total++;
			give_verdict();
		end
	end
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp)
		begin
			err_total++;
			$display("ERROR %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic give_verdict;
		if (err_total == 0 && compares > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : give_verdict
	// Writes a burst and expects an okay response.
	task automatic wrchk(input logic [31:0] a, input logic [7:0] l, input logic [2:0] s, input logic [1:0] b,
		input logic [31:0] d [$], input logic [3:0] st [$]);
		logic [1:0] rsp;
		m.wr(a, l, s, b, d, st, rsp);
		chk({30'h0, rsp}, {30'h0, bram_bridge_pkg::RESP_OKAY});
	endtask : wrchk
	// Reads a burst and compares every beat and the last flag.
	task automatic rdchk(input logic [31:0] a, input logic [7:0] l, input logic [1:0] b, input int stall,
		input logic [31:0] e [$]);
		logic [31:0] q [$];
		logic lst;
		m.rd(a, l, 3'h2, b, stall, q, lst);
		foreach (e[i])
			chk(q[i], e[i]);
		chk({31'h0, lst}, 32'h1);
	endtask : rdchk
	task automatic t_wrap;
		wrchk(32'h1000, 8'h3, 3'h2, bram_bridge_pkg::BURST_INCR, '{0, 0, 0, 0}, '{4'hF, 4'hF, 4'hF, 4'hF});
		wrchk(32'h1008, bram_bridge_pkg::WRAP_LEN_4, 3'h2, bram_bridge_pkg::BURST_WRAP,
			'{32'hD0, 32'hD1, 32'hD2, 32'hD3}, '{4'hF, 4'hF, 4'hF, 4'hF});
		wrchk(32'h100C, bram_bridge_pkg::WRAP_LEN_2, 3'h2, bram_bridge_pkg::BURST_WRAP,
			'{32'hE0, 32'hE1}, '{4'hF, 4'hF});
		rdchk(32'h1000, 8'h3, bram_bridge_pkg::BURST_INCR, -1, '{32'hD2, 32'hD3, 32'hE1, 32'hE0});
		rdchk(32'h1008, 8'h3, bram_bridge_pkg::BURST_WRAP, 1, '{32'hE1, 32'hE0, 32'hD2, 32'hD3});
	endtask : t_wrap
	task automatic t_narrow;
		// strobes alternate upper and lower halves.
		wrchk(32'h1002, 8'h3, 3'h1, bram_bridge_pkg::BURST_INCR, '{32'h1111_5555, 32'h5555_2222,
			32'h3333_5555, 32'h5555_4444}, '{4'hC, 4'h3, 4'hC, 4'h3});
		rdchk(32'h1000, 8'h2, bram_bridge_pkg::BURST_INCR, -1, '{32'h1111_00D2, 32'h3333_2222,
			32'h0000_4444});
		wrchk(32'h1002, bram_bridge_pkg::WRAP_LEN_4, 3'h1, bram_bridge_pkg::BURST_WRAP, '{32'h6666_5555,
			32'h5555_7777, 32'h8888_5555, 32'h5555_9999}, '{4'hC, 4'h3, 4'hC, 4'h3});
		rdchk(32'h1000, 8'h1, bram_bridge_pkg::BURST_INCR, 0, '{32'h6666_9999, 32'h8888_7777});
	endtask : t_narrow
	task automatic t_unaligned;
		// Clears the first word so its untouched low half reads back as a known value.
		wrchk(32'h1010, 8'h0, 3'h2, bram_bridge_pkg::BURST_INCR, '{32'h0}, '{4'hF});
		wrchk(32'h1012, 8'h1, 3'h2, bram_bridge_pkg::BURST_INCR, '{32'hAAAA_BBBB, 32'hCCCC_DDDD},
			'{4'hF, 4'hF});
		rdchk(32'h1010, 8'h1, bram_bridge_pkg::BURST_INCR, -1, '{32'hAAAA_0000, 32'hCCCC_DDDD});
	endtask : t_unaligned
	initial
	begin
		repeat (16) @(posedge CLK);
		RST <= 1'h0;
		@(posedge CLK);
		t_wrap();
		t_narrow();
		t_unaligned();
		give_verdict();
	end
endmodule : testbench
